// *** uart_transmitter.sv ***
// baud generator and asynchronous serial transmitter with break generation
// assumes an APB master on pclk; clear-to-send and clock pins are asynchronous
// What this block does
// [RULE1] divide reference by divisor 1 to 65535
// [RULE2] rate out equals factor times baud
// [RULE3] divisor is two 8-bit latches
// [RULE4] divisor write loads counter at once
// [RULE5] host programs both divisor latches first
// [RULE6] transmitter uses its own mode byte
// [RULE7] global byte sets stops and factor
// [RULE8] transmit needs enable and optional clear-to-send
// [RULE9] holding to shift, then framed character
// [RULE10] output changes on one clock edge
// [RULE11] line idles at mark
// [RULE12] host requests continuous, 4 or 16 break
// [RULE13] rewriting finite break extends it
// [RULE14] break character is all zero bits
// [RULE15] host ends continuous break with 00
// [RULE16] break bits self-clear at end or disable
// [RULE17] one mark bit after break
// [RULE18] held character sent after break
// [RULE19] break-sent flag set, cleared by read
// [RULE20] command bits 5:4 select break length
// [RULE21] 1x with 1.5 stops sends one
// [RULE22] underrun when holding and shift empty
// [RULE23] count down, reload gives one period
`timescale 1ns/1ps

module uart_transmitter #(
  parameter int ADDR_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clear_to_send_n,
  output logic serial_out,
  input wire logic transmit_clock_or_rate_out_level,
  output logic transmit_clock_or_rate_out,
  output logic transmit_clock_or_rate_out_en_n,
  input wire logic receive_clock_or_rate_out_level,
  output logic receive_clock_or_rate_out,
  output logic receive_clock_or_rate_out_en_n
);
  // -------------------------------------------------
  // state
  // -------------------------------------------------
  typedef struct packed {
    uart_tx_pkg::mode_t txm;     // transmitter mode
    uart_tx_pkg::mode_t rxm;     // receiver mode, kept apart
    uart_tx_pkg::gmode_t gm;     // shared stops and factor
    uart_tx_pkg::cmd_t cmd;      // command byte
    logic [15:0] div;            // divisor latches
    logic [7:0] thr;             // holding register
    logic thr_full;              // holding register loaded
    logic underrun;              // sticky underrun
    logic brk_sent;              // sticky break-sent flag
    logic [7:0] shreg;           // shift register
    logic [2:0] bitn;            // data bit index
    logic [6:0] smp;             // sample ticks within a bit
    logic par;                   // running parity
    logic brk_char;              // current character is a break
    uart_tx_pkg::tx_state_t fsm; // transmitter sequence
    logic [4:0] brk_left;        // finite break characters left
    logic txd;                   // serial line
    logic [2:0] cts_s;           // clear-to-send synchroniser
    logic cts_lvl;               // agreed clear-to-send level
    logic [2:0] tclk_s;          // external clock synchroniser
    logic tclk_lvl;              // agreed external clock level
    logic [31:0] rd;             // read data captured at setup
    logic err;                   // unmapped address at setup
  } st_t;

  st_t q, d;

  logic [3:0] idx;
  logic acc;
  logic mr_wr;
  logic div_wr;
  logic [15:0] div_new;
  logic baud_tick;
  logic rate_out;
  logic bclk_tick;
  logic tx_ok;
  logic brk_more;
  logic begin_char;
  logic [6:0] bit_lim;
  logic [6:0] stop_lim;
  logic [7:0] nsmp;
  logic bit_end;
  logic stop_end;
  logic mapped;
  logic [7:0] rdv;

  // values after reset; the divisor is handled apart
  function automatic st_t rst_f();
    st_t r;
    r = '0;
    r.txm = uart_tx_pkg::MODE_RESET;
    r.rxm = uart_tx_pkg::MODE_RESET;
    r.gm = uart_tx_pkg::MODE_RESET;
    r.cmd = uart_tx_pkg::MODE_RESET;
    r.div = uart_tx_pkg::DIV_RESET;
    r.fsm = uart_tx_pkg::TX_IDLE;
    r.txd = 1'b1;
    r.cts_s = uart_tx_pkg::SYNC_RESET;
    r.cts_lvl = 1'b1;
    r.tclk_s = uart_tx_pkg::SYNC_RESET;
    r.tclk_lvl = 1'b1;
    return r;
  endfunction

  // parity bit from the running xor
  function automatic logic par_bit(input logic [1:0] kind, input logic p);
    case (kind)
      uart_tx_pkg::PAR_ODD: par_bit = ~p;
      uart_tx_pkg::PAR_EVEN: par_bit = p;
      uart_tx_pkg::PAR_HIGH: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // -------------------------------------------------
  // bus decode
  // -------------------------------------------------
  assign idx = paddr[5:2];
  assign acc = psel & penable;
  assign mr_wr = acc & pwrite & (idx == uart_tx_pkg::IDX_MRESET);
  // zero wait states: read data is captured during setup
  assign pready = 1'b1;
  assign pslverr = acc & q.err;
  assign prdata = q.rd;

  // read mux and map check
  always_comb begin
    mapped = 1'b1;
    rdv = 8'h00;
    case (idx)
      uart_tx_pkg::IDX_RXMODE: rdv = q.rxm;
      uart_tx_pkg::IDX_TXMODE: rdv = q.txm;
      uart_tx_pkg::IDX_GMODE: rdv = {4'h0, q.gm[3:0]};
      uart_tx_pkg::IDX_CMD: rdv = q.cmd;
      uart_tx_pkg::IDX_DIVLO: rdv = q.div[7:0];
      uart_tx_pkg::IDX_DIVHI: rdv = q.div[15:8];
      uart_tx_pkg::IDX_STATUS: begin
        rdv[uart_tx_pkg::ST_TXBE] = ~q.thr_full;
        rdv[uart_tx_pkg::ST_UNDERRUN] = q.underrun;
        rdv[uart_tx_pkg::ST_BRKSENT] = q.brk_sent;
      end
      uart_tx_pkg::IDX_THR, uart_tx_pkg::IDX_MRESET: rdv = 8'h00;
      default: mapped = 1'b0;
    endcase
  end

  // -------------------------------------------------
  // baud generator
  // -------------------------------------------------
  baud_rate_counter u_brc (
    .pclk(pclk),
    .presetn(presetn),
    .load(div_wr),
    .div_load(div_new),
    .div(q.div),
    .tick(baud_tick),
    .rate_out(rate_out)
  );

  // [RULE2] drive pins when internal clock selected
  assign transmit_clock_or_rate_out = rate_out;
  assign transmit_clock_or_rate_out_en_n = ~q.txm.int_clk;
  assign receive_clock_or_rate_out = rate_out;
  assign receive_clock_or_rate_out_en_n = ~q.rxm.int_clk;
  assign serial_out = q.txd;

  // -------------------------------------------------
  // next state
  // -------------------------------------------------
  always_comb begin
    d = q;
    div_wr = 1'b0;
    div_new = q.div;
    begin_char = 1'b0;
    // pins pass three flops; a level counts once the last two agree
    d.cts_s = {q.cts_s[1:0], clear_to_send_n};
    if (q.cts_s[1] == q.cts_s[2]) begin
      d.cts_lvl = q.cts_s[2];
    end
    d.tclk_s = {q.tclk_s[1:0], transmit_clock_or_rate_out_level};
    if (q.tclk_s[1] == q.tclk_s[2]) begin
      d.tclk_lvl = q.tclk_s[2];
    end
    // [RULE10] falling pin edge, rising edge of its complement
    // [RULE6] transmitter clock source from its own mode
    bclk_tick = q.txm.int_clk ? baud_tick : (q.tclk_lvl & ~d.tclk_lvl);
    // [RULE8] enable plus optional clear-to-send
    tx_ok = q.cmd.tx_en & (~q.txm.auto_cts | ~q.cts_lvl);
    brk_more = tx_ok & (q.cmd.brk != uart_tx_pkg::BRK_NONE);
    // [RULE7] shared factor and stop count
    bit_lim = uart_tx_pkg::SMP_M1[q.gm.factor];
    nsmp = {1'b0, bit_lim} + 8'h01;
    // [RULE21] 1x turns one and a half into one
    if (q.gm.stops == uart_tx_pkg::STOP_ONE) begin
      stop_lim = bit_lim;
    end else if (q.gm.stops == uart_tx_pkg::STOP_ONE_HALF) begin
      stop_lim = (q.gm.factor == 2'h0) ? bit_lim : 7'(nsmp + {1'b0, nsmp[7:1]} - 8'h01);
    end else begin
      stop_lim = 7'({nsmp[6:0], 1'b0} - 8'h01);
    end
    bit_end = bclk_tick & (q.smp == bit_lim);
    stop_end = bclk_tick & (q.smp == stop_lim);
    // [RULE19] read clears only what was shown
    if (acc & ~pwrite & (idx == uart_tx_pkg::IDX_STATUS)) begin
      if (q.rd[uart_tx_pkg::ST_UNDERRUN]) begin
        d.underrun = 1'b0;
      end
      if (q.rd[uart_tx_pkg::ST_BRKSENT]) begin
        d.brk_sent = 1'b0;
      end
    end
    // [RULE16] disable cancels a break
    if (~tx_ok & (q.cmd.brk != uart_tx_pkg::BRK_NONE)) begin
      d.cmd.brk = uart_tx_pkg::BRK_NONE;
    end
    // bit sequencing, one step per sample tick
    if (bclk_tick) begin
      d.smp = q.smp + 7'h01;
      unique case (q.fsm)
        uart_tx_pkg::TX_IDLE: begin
          d.smp = 7'h00;
          begin_char = 1'b1;
        end
        uart_tx_pkg::TX_START: if (bit_end) begin
          d.smp = 7'h00;
          d.fsm = uart_tx_pkg::TX_DATA;
          d.bitn = 3'h0;
          d.txd = ~q.brk_char & q.shreg[0];
        end
        uart_tx_pkg::TX_DATA: if (bit_end) begin
          // [RULE9] shift data out, lsb first
          d.smp = 7'h00;
          d.par = q.par ^ q.shreg[0];
          d.shreg = {1'b0, q.shreg[7:1]};
          d.bitn = q.bitn + 3'h1;
          if (q.bitn == {1'b1, q.txm.len}) begin
            if (q.txm.par_en) begin
              d.fsm = uart_tx_pkg::TX_PARITY;
              d.txd = ~q.brk_char & par_bit(q.txm.par_type, d.par);
            end else begin
              d.fsm = uart_tx_pkg::TX_STOP;
              d.txd = ~q.brk_char;
            end
          end else begin
            // [RULE14] break keeps every bit low
            d.txd = ~q.brk_char & q.shreg[1];
          end
        end
        uart_tx_pkg::TX_PARITY: if (bit_end) begin
          d.smp = 7'h00;
          d.fsm = uart_tx_pkg::TX_STOP;
          d.txd = ~q.brk_char;
        end
        uart_tx_pkg::TX_STOP: if (stop_end) begin
          d.smp = 7'h00;
          // [RULE11] back to mark after the stop bits
          d.txd = 1'b1;
          // [RULE17] break end forces a mark bit
          if (q.brk_char & ~brk_more) begin
            d.fsm = uart_tx_pkg::TX_MARK;
          end else begin
            d.fsm = uart_tx_pkg::TX_IDLE;
            begin_char = 1'b1;
          end
        end
        uart_tx_pkg::TX_MARK: if (bit_end) begin
          d.smp = 7'h00;
          d.fsm = uart_tx_pkg::TX_IDLE;
          begin_char = 1'b1;
        end
        default: begin
          d.fsm = uart_tx_pkg::TX_IDLE;
          d.txd = 1'b1;
        end
      endcase
    end
    // character boundary: break first, the held byte waits
    if (begin_char) begin
      if (brk_more) begin
        // [RULE14] start an all-zero character
        d.fsm = uart_tx_pkg::TX_START;
        d.txd = 1'b0;
        d.brk_char = 1'b1;
        d.par = 1'b0;
        // [RULE19] flag each continuous or last finite character
        if (q.cmd.brk == uart_tx_pkg::BRK_CONT) begin
          d.brk_sent = 1'b1;
        end else if (q.brk_left <= 5'h01) begin
          // [RULE16] last finite character clears bits
          d.brk_sent = 1'b1;
          d.cmd.brk = uart_tx_pkg::BRK_NONE;
        end else begin
          d.brk_left = q.brk_left - 5'h01;
        end
      end else if (tx_ok & q.thr_full) begin
        // [RULE9] parallel load from holding register
        // [RULE18] held byte goes only once break ends
        d.fsm = uart_tx_pkg::TX_START;
        d.txd = 1'b0;
        d.brk_char = 1'b0;
        d.shreg = q.thr;
        d.thr_full = 1'b0;
        d.par = 1'b0;
      end
    end
    // [RULE22] nothing held and nothing shifting
    if ((q.fsm == uart_tx_pkg::TX_IDLE) & ~q.thr_full) begin
      d.underrun = 1'b1;
    end
    // read data and map check are captured in the setup cycle
    if (psel & ~penable) begin
      d.rd = {24'h000000, rdv};
      d.err = ~mapped;
    end
    // software writes land last so that a rewrite wins
    if (acc & pwrite) begin
      case (idx)
        uart_tx_pkg::IDX_THR: begin
          d.thr = pwdata[7:0];
          d.thr_full = 1'b1;
        end
        uart_tx_pkg::IDX_RXMODE: d.rxm = pwdata[7:0];
        uart_tx_pkg::IDX_TXMODE: d.txm = pwdata[7:0];
        uart_tx_pkg::IDX_GMODE: d.gm = {4'h0, pwdata[3:0]};
        uart_tx_pkg::IDX_CMD: begin
          // [RULE20] bits 5:4 pick the length
          // [RULE13] a rewrite reloads the count
          d.cmd = pwdata[7:0];
          d.brk_left = (pwdata[5:4] == uart_tx_pkg::BRK_FOUR) ? uart_tx_pkg::BRK_LEN_FOUR
                                                               : uart_tx_pkg::BRK_LEN_SIXTEEN;
        end
        uart_tx_pkg::IDX_DIVLO: begin
          // [RULE3] low latch of the divisor
          div_new = {q.div[15:8], pwdata[7:0]};
          d.div = div_new;
          div_wr = 1'b1;
        end
        uart_tx_pkg::IDX_DIVHI: begin
          div_new = {pwdata[7:0], q.div[7:0]};
          d.div = div_new;
          div_wr = 1'b1;
        end
        default: ;
      endcase
    end
    // master reset write: all but the divisor and the synchronisers
    if (mr_wr) begin
      d = rst_f();
      d.div = q.div;
      d.cts_s = q.cts_s;
      d.cts_lvl = q.cts_lvl;
      d.tclk_s = q.tclk_s;
      d.tclk_lvl = q.tclk_lvl;
    end
  end

  // the whole state in one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= rst_f();
    end else begin
      q <= d;
    end
  end

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_brk_end;
    (q.fsm == uart_tx_pkg::TX_STOP) && q.brk_char && stop_end && !brk_more && !mr_wr;
  endsequence
  sequence s_mark_bit;
    (q.fsm == uart_tx_pkg::TX_MARK) && q.txd && (q.smp == 7'h00);
  endsequence

  property p_idle_mark;
    (q.fsm == uart_tx_pkg::TX_IDLE) |-> q.txd;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not at mark while idle"); // [RULE11]

  property p_brk_low;
    (q.brk_char && (q.fsm inside {uart_tx_pkg::TX_START, uart_tx_pkg::TX_DATA,
      uart_tx_pkg::TX_PARITY, uart_tx_pkg::TX_STOP})) |-> !q.txd;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break character bit not low"); // [RULE14]

  property p_mark_after;
    s_brk_end |=> s_mark_bit;
  endproperty
  a_mark_after: assert property (p_mark_after) else $error("no mark bit after break"); // [RULE17]

  property p_mark_hold;
    ((q.fsm == uart_tx_pkg::TX_MARK) && !bit_end && !mr_wr) |=> (q.fsm == uart_tx_pkg::TX_MARK);
  endproperty
  a_mark_hold: assert property (p_mark_hold) else $error("mark bit cut short"); // [RULE17]

  property p_brk_disable;
    (!tx_ok && (q.cmd.brk != uart_tx_pkg::BRK_NONE) && !(acc && pwrite)) |=>
      (q.cmd.brk == uart_tx_pkg::BRK_NONE);
  endproperty
  a_brk_disable: assert property (p_brk_disable) else $error("break bits kept after disable"); // [RULE16]

  property p_thr_kept;
    ((q.cmd.brk != uart_tx_pkg::BRK_NONE) && q.thr_full && !mr_wr) |=> q.thr_full;
  endproperty
  a_thr_kept: assert property (p_thr_kept) else $error("held byte taken during break"); // [RULE18]

  property p_underrun;
    ((q.fsm == uart_tx_pkg::TX_IDLE) && !q.thr_full && !mr_wr) |=> q.underrun;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not raised"); // [RULE22]

  property p_txd_edge;
    $changed(q.txd) |-> $past(bclk_tick || mr_wr);
  endproperty
  a_txd_edge: assert property (p_txd_edge) else $error("line changed off the bit clock"); // [RULE10]

  property p_brk_flag;
    (begin_char && brk_more && (q.cmd.brk == uart_tx_pkg::BRK_CONT) && !mr_wr) |=> q.brk_sent;
  endproperty
  a_brk_flag: assert property (p_brk_flag) else $error("break-sent flag not set"); // [RULE19]
endmodule

// *** baud_rate_counter.sv ***
// shared constants and types, plus the 16-bit baud rate counter
// assumes a single clock pclk and an asynchronous active-low reset presetn
`timescale 1ns/1ps

package uart_tx_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_THR = 4'h0;
  localparam logic [3:0] IDX_RXMODE = 4'h1;
  localparam logic [3:0] IDX_TXMODE = 4'h2;
  localparam logic [3:0] IDX_GMODE = 4'h3;
  localparam logic [3:0] IDX_CMD = 4'h4;
  localparam logic [3:0] IDX_DIVLO = 4'h5;
  localparam logic [3:0] IDX_DIVHI = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h8;
  localparam logic [3:0] IDX_MRESET = 4'hC;
  // status bit positions
  localparam int ST_TXBE = 1;
  localparam int ST_UNDERRUN = 2;
  localparam int ST_BRKSENT = 6;
  // break control codes in command bits 5:4
  localparam logic [1:0] BRK_NONE = 2'h0;
  localparam logic [1:0] BRK_CONT = 2'h1;
  localparam logic [1:0] BRK_FOUR = 2'h2;
  localparam logic [1:0] BRK_SIXTEEN = 2'h3;
  localparam logic [4:0] BRK_LEN_FOUR = 5'h04;
  localparam logic [4:0] BRK_LEN_SIXTEEN = 5'h10;
  // parity kinds
  localparam logic [1:0] PAR_ODD = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_HIGH = 2'h2;
  // stop bit codes
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_ONE_HALF = 2'h1;
  // samples per bit minus one for 1x, 16x, 32x, 64x
  localparam logic [3:0][6:0] SMP_M1 = {7'h3F, 7'h1F, 7'h0F, 7'h00};
  // values after reset
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // transmitter or receiver mode byte
  typedef struct packed {
    logic spare;
    logic int_clk;
    logic auto_cts;
    logic [1:0] par_type;
    logic par_en;
    logic [1:0] len;
  } mode_t;

  // global mode byte
  typedef struct packed {
    logic [3:0] spare;
    logic [1:0] factor;
    logic [1:0] stops;
  } gmode_t;

  // command byte
  typedef struct packed {
    logic dtr;
    logic rts;
    logic [1:0] brk;
    logic diag_en;
    logic diag_sel;
    logic tx_en;
    logic rx_en;
  } cmd_t;

  // transmitter sequence, gray from idle through parity to mark
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_PARITY = 3'h2,
    TX_STOP = 3'h6,
    TX_MARK = 3'h7
  } tx_state_t;
endpackage

module baud_rate_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [15:0] div_load,
  input wire logic [15:0] div,
  output logic tick,
  output logic rate_out
);
  // -------------------------------------------------
  // state
  // -------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt;
    logic out;
  } brc_t;

  brc_t q, d;

  // count down, reload at terminal count; a zero divisor holds the counter
  always_comb begin
    d = q;
    tick = 1'b0;
    if (load) begin
      // [RULE4] immediate counter load
      d.cnt = div_load;
    end else if (div != uart_tx_pkg::DIV_RESET) begin
      // [RULE23] reload gives one period
      if (q.cnt <= 16'h0001) begin
        d.cnt = div;
        tick = 1'b1;
      end else begin
        d.cnt = q.cnt - 16'h0001;
      end
    end
    // [RULE1] high for the upper half of the count
    d.out = d.cnt > {1'b0, div[15:1]};
  end

  // registered state; an unprogrammed divisor keeps the generator quiet
  // [RULE5] relies on divisor programming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rate_out = q.out;

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  logic [15:0] gap_q;
  logic seen_q;

  // helper: cycles since the last tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= tick ? 16'h0000 : gap_q + 16'h0001;
      seen_q <= load ? 1'b0 : (seen_q | tick);
    end
  end

  property p_div_load;
    @(posedge pclk) disable iff (!presetn) load |=> (q.cnt == $past(div_load));
  endproperty
  a_div_load: assert property (p_div_load) else $error("counter not loaded on divisor write"); // [RULE4]

  property p_period;
    @(posedge pclk) disable iff (!presetn) (tick && seen_q && !load) |-> (gap_q == div - 16'h0001);
  endproperty
  a_period: assert property (p_period) else $error("tick period differs from divisor"); // [RULE23]
endmodule

// *** remote_receiver.sv ***
// remote asynchronous receiver standing on the far side of serial_out
// assumes 8 data bits, no parity, one stop bit, BIT pclk cycles per bit
`timescale 1ns/1ps

module remote_receiver #(
  parameter int BIT = 32
) (
  input wire logic pclk,
  input wire logic line,
  output logic [7:0] rx_byte,
  output logic rx_stop,
  output int rx_cnt
);
  // --------------------------------------------------------------
  // frame sampler
  // --------------------------------------------------------------
  // samples mid-bit; a long low line (break) yields one frame only,
  // since a new frame needs a fresh falling edge
  initial begin
    rx_cnt = 0;
    rx_byte = 8'h00;
    rx_stop = 1'b1;
    forever begin
      @(negedge line);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge pclk);
        rx_byte[i] = line;
      end
      repeat (BIT) @(posedge pclk);
      rx_stop = line;
      rx_cnt++;
    end
  end
endmodule

// *** baud_generator_and_serial_transmitter_tb_top.sv ***
// self-checking bench for the transmitter with its APB register port
// assumes the remote receiver model and 16x factor with divisor 2
`timescale 1ns/1ps

module baud_generator_and_serial_transmitter_tb_top;
  logic pclk, presetn, psel, penable, pwrite, serial_out, slverr, tx_en_n, rx_en_n, tx_o, rx_o, cts_n, last_pin;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, edges;
  logic pready, pslverr;
  logic [7:0] rx_byte, exp_b;
  logic rx_stop;
  int rx_cnt, error_cnt, checks_done;
  // unselected clock pins float high through a pull-up
  wire tx_pin = tx_en_n ? 1'b1 : tx_o;
  wire rx_pin = rx_en_n ? 1'b1 : rx_o;

  uart_transmitter i_uart_transmitter (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_to_send_n(cts_n), .serial_out(serial_out), .transmit_clock_or_rate_out_level(tx_pin),
    .transmit_clock_or_rate_out(tx_o), .transmit_clock_or_rate_out_en_n(tx_en_n),
    .receive_clock_or_rate_out_level(rx_pin), .receive_clock_or_rate_out(rx_o),
    .receive_clock_or_rate_out_en_n(rx_en_n));
  remote_receiver #(.BIT(32)) i_remote_receiver (.pclk(pclk), .line(serial_out), .rx_byte(rx_byte),
    .rx_stop(rx_stop), .rx_cnt(rx_cnt));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // wait for the receiver to finish n more frames
  task automatic wait_rx(input int n);
    int k, t;
    k = rx_cnt + n;
    for (t = 0; t < 6000 && rx_cnt < k; t++) @(posedge pclk);
    if (rx_cnt < k) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, cts_n} = 5'h00;
    paddr = 6'h00;
    pwdata = 32'h00000000;
    error_cnt = 0;
    checks_done = 0;
    seed = 32'h00016255;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check("idle line", {31'h0, serial_out}, 32'h00000001);
    apb(1'b0, 4'h8, 8'h00);
    check("status empty", rd & 32'h02, 32'h00000002);
    apb(1'b0, 4'h8, 8'h00);
    check("underrun", rd & 32'h04, 32'h00000004);
    apb(1'b0, 4'h7, 8'h00);
    check("unmapped err", {31'h0, slverr}, 32'h00000001);
    apb(1'b1, 4'h3, 8'hF4);
    apb(1'b0, 4'h3, 8'h00);
    check("gmode", rd, 32'h00000004);
    $display("test registers done");
    // setup: divisor 2, 8 bits, internal clock, 16x, one stop
    // both divisor latches before enabling
    apb(1'b1, 4'h5, 8'h02);
    apb(1'b1, 4'h6, 8'h00);
    apb(1'b1, 4'h2, 8'h43);
    apb(1'b1, 4'h4, 8'h02);
    check("clock pin driven", {31'h0, tx_en_n}, 32'h00000000);
    check("rx clock pin released", {31'h0, rx_en_n}, 32'h00000001);
    // divisor 2 gives one generator period per two clocks
    edges = 32'h00000000;
    last_pin = tx_pin;
    repeat (32) begin
      @(posedge pclk);
      edges = edges + {31'h0, tx_pin & ~last_pin};
      last_pin = tx_pin;
    end
    check("rate out edges", edges, 32'h00000010);
    for (int j = 0; j < 6; j++) begin
      seed = lfsr(seed);
      exp_b = (j == 0) ? 8'hFF : seed[7:0];
      apb(1'b1, 4'h0, exp_b);
      wait_rx(1);
      check("char", {23'h0, rx_stop, rx_byte}, {23'h0, 1'b1, exp_b});
    end
    $display("test characters done");
    // auto enable keeps the byte until clear-to-send is low
    cts_n <= 1'b1;
    apb(1'b1, 4'h2, 8'h63);
    apb(1'b1, 4'h0, 8'h3C);
    repeat (400) @(posedge pclk);
    apb(1'b0, 4'h8, 8'h00);
    check("held by cts", rd & 32'h02, 32'h00000000);
    cts_n <= 1'b0;
    wait_rx(1);
    check("char after cts", {23'h0, rx_stop, rx_byte}, 32'h0000013C);
    $display("test auto enable done");
    // four-character break with a byte held behind it
    apb(1'b1, 4'h4, 8'h22);
    apb(1'b1, 4'h0, 8'hA5);
    wait_rx(1);
    check("break char", {23'h0, rx_stop, rx_byte}, 32'h00000000);
    wait_rx(1);
    check("held char", {23'h0, rx_stop, rx_byte}, 32'h000001A5);
    apb(1'b0, 4'h4, 8'h00);
    check("break bits cleared", rd, 32'h00000002);
    apb(1'b0, 4'h8, 8'h00);
    check("break sent", rd & 32'h40, 32'h00000040);
    $display("test break done");
    // continuous break, ended by the host
    apb(1'b1, 4'h4, 8'h12);
    wait_rx(1);
    check("long break char", {23'h0, rx_stop, rx_byte}, 32'h00000000);
    apb(1'b0, 4'h8, 8'h00);
    check("long break sent", rd & 32'h40, 32'h00000040);
    // writing 00 to the break bits ends it
    apb(1'b1, 4'h4, 8'h02);
    seed = lfsr(seed);
    apb(1'b1, 4'h0, seed[7:0]);
    wait_rx(1);
    check("char after long break", {23'h0, rx_stop, rx_byte}, {23'h0, 1'b1, seed[7:0]});
    $display("test continuous break done");
    // master reset clears the command byte but keeps the divisor
    apb(1'b1, 4'hC, 8'h00);
    apb(1'b0, 4'h4, 8'h00);
    check("cmd after master reset", rd, 32'h00000000);
    apb(1'b0, 4'h5, 8'h00);
    check("divisor kept", rd, 32'h00000002);
    $display("test master reset done");
    tally_and_finish();
  end
endmodule
